// file: hw/stqt_regs.vh
// address map, field positions and timing counts of the threshold/queue/timer block
`ifndef STQT_REGS_VH
`define STQT_REGS_VH
// host word addresses: 32-bit words sit at even addresses, bit 0 is zero
`define STQT_CNT_BASE 18'h20000
`define STQT_CNT_LAST 18'h21FFF
`define STQT_THR_BASE 18'h22000
`define STQT_THR_LAST 18'h23FFF
`define STQT_IRQ_QUEUE_ENTRY 18'h24000
`define STQT_IRQ_QUEUE_LAST 18'h25FFF
`define STQT_TIMER_WORD 18'h26000
`define STQT_TIMER_LAST 18'h2601F
`define STQT_INSERT_CELL_HEADER 18'h26020
`define STQT_INSERT_LAST 18'h2603F
`define STQT_INSERT_PAY_FIRST 18'h26024
`define STQT_INSERT_PAY_LAST 18'h2603B
`define STQT_EXTRACT_CELL_AREA 18'h26040
`define STQT_EXTRACT_LAST 18'h27FFF
`define STQT_CTRL 18'h00100
`define STQT_STATUS 18'h00104
`define STQT_QLEVEL 18'h00108
// threshold and counter words
`define STQT_THR_ACT_BIT 31
`define STQT_INT_GEN_BIT 31
`define STQT_CNT_SAT 31'h40000000
// queue entry fields
`define STQT_QE_NONEMPTY_BIT 15
`define STQT_QE_PORT_LSB 9
`define STQT_QE_CHAN_LSB 4
`define STQT_QE_CNTR_LSB 0
// timer word fields
`define STQT_TMR_RUN_BIT 15
`define STQT_TMR_STOP_VALUE 15'h7FFF
`define STQT_TMR_SET_BIT 3
`define STQT_TICK_MULT 12
`define STQT_TICK_DIV 512
// control register bits
`define STQT_CTRL_SET1_EN_BIT 0
`define STQT_CTRL_SET2_EN_BIT 1
`define STQT_CTRL_RESET 32'h00000003
// inserted cell header layout
`define STQT_HDR_VCI_LO_LSB 28
`define STQT_HDR_PTI_LSB 25
`define STQT_HDR_CLP_BIT 24
`define STQT_HDR_VCI_MID_LSB 16
`define STQT_HDR_VPI_LO_LSB 12
`define STQT_HDR_VCI_HI_LSB 8
`define STQT_HDR_GFC_LSB 4
`define STQT_HDR_VPI_MID_LSB 0
`endif

// file: hw/stqt_top.v
// statistics thresholds, interrupt queue, timers and cell buffers behind apb
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
// What this block does
// [R1] threshold word: bit 31 enable, bits 30:0 threshold level, one per counter
// [R2] thresholds above counter saturation never produce a queue entry
// [R3] enabled counter reaching threshold writes entry: counter, channel, port
// [R4] entry bit 15 shows whether further entries remain in the queue
// [R5] two timer sets of eight timers, one word each
// [R6] timer index bit 3: 0 picks set two, 1 picks set one
// [R7] timer word: run bit 15, count 14:0, upper bits unused
// [R8] software starts, stops or pauses a timer by writing run bit
// [R9] run bit clears by itself when the count reaches zero; here it clears one tick later, as the count goes to 7FFF
// [R10] running count decrements every 12 x 512 clock periods
// [R11] expired count stops at 7FFF and sets that set's status bit
// [R12] set enable bits at zero freeze all timers of that set
// [R13] insertion buffer: one 16-word cell, header at base, payload 26024-2603B
// [R14] software writes inserted cell header at word 26020
// [R15] header word packs vci, pti, clp, vpi and gfc in fixed fields
// [R16] extraction buffer holds 254 cells of 16 words
// [R17] memories are not reset; software initialises them before use
// [R18] statistics counter saturates at 4000_0000
// [R19] one queue entry per counter, recorded in counter bit 31
// [R20] software reads entries in order, stops at not-empty flag zero
// [R21] counter compared with threshold only when threshold is enabled
`include "stqt_regs.vh"

module stqt_top #(
  parameter CNT_DEPTH = 4096,
  parameter QUEUE_DEPTH = 4096,
  parameter EXTRACT_CELLS = 254,
  parameter TICK_CYCLES = `STQT_TICK_MULT * `STQT_TICK_DIV
) (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire cnt_inc_valid,
  input wire [11:0] cnt_inc_index,
  output wire cnt_inc_ready,
  output reg [31:0] insert_header,
  output wire timer_set1_irq_pin,
  output wire timer_set2_irq_pin
);
  localparam QW = 12;
  localparam XWORDS = EXTRACT_CELLS * 16;

  // word memories, none of them cleared by reset
  reg [31:0] cnt_mem [0:CNT_DEPTH-1]; // [R17]
  reg [31:0] thr_mem [0:CNT_DEPTH-1];
  reg [15:0] q_mem [0:QUEUE_DEPTH-1];
  reg [15:0] tmr_mem [0:15]; // [R5]
  reg [31:0] ins_mem [0:15];
  reg [31:0] ext_mem [0:XWORDS-1];

  reg [QW:0] q_wr_ptr;
  reg [QW:0] q_rd_ptr;
  reg [31:0] ctrl;
  reg [7:0] irq_status_one;
  reg [7:0] irq_status_two;
  reg [12:0] tick_cnt;
  reg tick;

  wire [17:0] host_word_addr;
  wire set_one_enable;
  wire set_two_enable;
  wire setup_ph;
  wire access_ph;
  wire wr_acc;

  function in_range;
    input [17:0] a;
    input [17:0] lo;
    input [17:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // word offset inside a region, with half-word stride
  function [12:0] word_off;
    input [17:0] a;
    input [17:0] lo;
    reg [17:0] d;
    begin
      d = a - lo;
      word_off = d[13:1];
    end
  endfunction

  assign host_word_addr = paddr[17:0];
  assign set_one_enable = ctrl[`STQT_CTRL_SET1_EN_BIT];
  assign set_two_enable = ctrl[`STQT_CTRL_SET2_EN_BIT];
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  // every access has exactly one wait-free access phase after setup
  assign pready = 1'b1;

  // bit 0 and every bit above 17 must be zero for a mapped word
  wire odd_addr = paddr[0] | (|paddr[31:18]);
  wire sel_cnt = in_range(host_word_addr, `STQT_CNT_BASE, `STQT_CNT_LAST);
  wire sel_thr = in_range(host_word_addr, `STQT_THR_BASE, `STQT_THR_LAST);
  wire sel_q = in_range(host_word_addr, `STQT_IRQ_QUEUE_ENTRY,
                        `STQT_IRQ_QUEUE_LAST);
  wire sel_tmr = in_range(host_word_addr, `STQT_TIMER_WORD,
                          `STQT_TIMER_LAST);
  wire sel_ins = in_range(host_word_addr, `STQT_INSERT_CELL_HEADER,
                          `STQT_INSERT_LAST);
  wire sel_ext = in_range(host_word_addr, `STQT_EXTRACT_CELL_AREA,
                          `STQT_EXTRACT_LAST);
  wire sel_ctrl = host_word_addr == `STQT_CTRL;
  wire sel_stat = host_word_addr == `STQT_STATUS;
  wire sel_lvl = host_word_addr == `STQT_QLEVEL;
  wire mapped = !odd_addr && (sel_cnt || sel_thr || sel_q || sel_tmr ||
                sel_ins || sel_ext || sel_ctrl || sel_stat || sel_lvl);
  assign wr_acc = access_ph && pwrite && mapped;

  wire [12:0] cnt_off = word_off(host_word_addr, `STQT_CNT_BASE);
  wire [12:0] thr_off = word_off(host_word_addr, `STQT_THR_BASE);
  wire [12:0] q_off = word_off(host_word_addr, `STQT_IRQ_QUEUE_ENTRY);
  wire [12:0] tmr_off = word_off(host_word_addr, `STQT_TIMER_WORD);
  wire [12:0] ins_off = word_off(host_word_addr, `STQT_INSERT_CELL_HEADER);
  wire [12:0] ext_off = word_off(host_word_addr, `STQT_EXTRACT_CELL_AREA);

  // ---------------- interrupt queue state ----------------
  // pointers carry one extra bit so that full and empty differ
  wire [QW:0] q_level = q_wr_ptr - q_rd_ptr;
  wire q_empty = q_level == {(QW+1){1'b0}};
  wire q_full = q_level == QUEUE_DEPTH[QW:0];
  // pop in the setup cycle, so the access phase shows the popped entry
  wire q_pop = setup_ph && !pwrite && !odd_addr && sel_q && !q_empty;

  // ---------------- counter update and threshold check ----------------
  // an apb write into the counter or queue memory takes the port this cycle
  assign cnt_inc_ready = !(wr_acc && (sel_cnt || sel_q));
  wire cnt_step = cnt_inc_valid && cnt_inc_ready;
  wire [31:0] cnt_word = cnt_mem[cnt_inc_index];
  wire [31:0] thr_word = thr_mem[cnt_inc_index];
  wire [30:0] cnt_val = cnt_word[30:0];
  wire [30:0] thr_val = thr_word[30:0]; // [R1]
  wire cnt_sat = cnt_val >= `STQT_CNT_SAT;
  wire [30:0] cnt_next = cnt_sat ? `STQT_CNT_SAT : cnt_val + 31'h00000001; // [R18]
  // thresholds past saturation are unreachable by design
  wire thr_hit = thr_word[`STQT_THR_ACT_BIT] && // [R21]
                 (thr_val <= `STQT_CNT_SAT) && // [R2]
                 (cnt_next >= thr_val) &&
                 !cnt_word[`STQT_INT_GEN_BIT]; // [R19]
  // a full queue loses the entry; the flag stays clear so a later count retries
  wire q_push = cnt_step && thr_hit && !q_full;
  wire [15:0] q_entry = {4'h0, cnt_inc_index[11:9], cnt_inc_index[8:4],
                         cnt_inc_index[3:0]}; // [R3]

  // increment and apb write never meet: ready is low during such writes
  always @(posedge clk_sys) begin
    if (cnt_step) begin
      cnt_mem[cnt_inc_index] <= {cnt_word[`STQT_INT_GEN_BIT] | q_push,
                                 cnt_next}; // [R19]
    end else if (wr_acc && sel_cnt) begin
      cnt_mem[cnt_off[11:0]] <= pwdata;
    end
  end

  always @(posedge clk_sys) begin
    if (wr_acc && sel_thr) begin
      thr_mem[thr_off[11:0]] <= pwdata; // [R1]
    end
  end

  always @(posedge clk_sys) begin
    if (q_push) begin
      q_mem[q_wr_ptr[QW-1:0]] <= q_entry; // [R3]
    end else if (wr_acc && sel_q) begin
      q_mem[q_off[11:0]] <= pwdata[15:0];
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      q_wr_ptr <= {(QW+1){1'b0}};
      q_rd_ptr <= {(QW+1){1'b0}};
    end else begin
      if (q_push) begin
        q_wr_ptr <= q_wr_ptr + {{QW{1'b0}}, 1'b1};
      end
      if (q_pop) begin
        q_rd_ptr <= q_rd_ptr + {{QW{1'b0}}, 1'b1}; // [R20]
      end
    end
  end

  // ---------------- timers ----------------
  // one shared prescaler: a timer started mid-period sees a short first step
  always @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt <= 13'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[12:0] - 13'h0001) begin
      tick_cnt <= 13'h0000;
      tick <= 1'b1; // [R10]
    end else begin
      tick_cnt <= tick_cnt + 13'h0001;
      tick <= 1'b0;
    end
  end

  reg [7:0] next_status_one;
  reg [7:0] next_status_two;
  integer i;
  integer j;

  // an apb write wins over a tick in the same cycle
  always @(posedge clk_sys) begin
    for (i = 0; i < 16; i = i + 1) begin
      if (wr_acc && sel_tmr && tmr_off[3:0] == i) begin
        tmr_mem[i] <= pwdata[15:0]; // [R8]
      end else if (tick && tmr_mem[i][`STQT_TMR_RUN_BIT] &&
                   ((i >= 8) ? set_one_enable : set_two_enable)) begin // [R12]
        if (tmr_mem[i][14:0] == 15'h0000) begin
          tmr_mem[i] <= {1'b0, `STQT_TMR_STOP_VALUE}; // [R9] [R11]
        end else begin
          tmr_mem[i] <= {1'b1, tmr_mem[i][14:0] - 15'h0001}; // [R10]
        end
      end
    end
  end

  // expiry events per timer; index bit 3 high means set one
  always @* begin
    next_status_one = irq_status_one;
    next_status_two = irq_status_two;
    // status bits are write-one-to-clear
    if (wr_acc && sel_stat) begin
      next_status_one = next_status_one & ~pwdata[7:0];
      next_status_two = next_status_two & ~pwdata[15:8];
    end
    for (j = 0; j < 8; j = j + 1) begin
      if (tick && set_one_enable && tmr_mem[j+8][`STQT_TMR_RUN_BIT] &&
          tmr_mem[j+8][14:0] == 15'h0000) begin
        next_status_one[j] = 1'b1; // [R6] [R11]
      end
      if (tick && set_two_enable && tmr_mem[j][`STQT_TMR_RUN_BIT] &&
          tmr_mem[j][14:0] == 15'h0000) begin
        next_status_two[j] = 1'b1; // [R6] [R11]
      end
    end
  end

  // expiry in the clearing cycle survives: the set is applied after the clear
  always @(posedge clk_sys) begin
    if (rst) begin
      irq_status_one <= 8'h00;
      irq_status_two <= 8'h00;
    end else begin
      irq_status_one <= next_status_one;
      irq_status_two <= next_status_two;
    end
  end

  assign timer_set1_irq_pin = |irq_status_one; // [R6]
  assign timer_set2_irq_pin = |irq_status_two; // [R6]

  // ---------------- control and cell buffers ----------------
  // only the two enable bits exist; the rest reads back as zero
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `STQT_CTRL_RESET;
    end else if (wr_acc && sel_ctrl) begin
      ctrl <= {30'h00000000, pwdata[1:0]}; // [R12]
    end
  end

  // payload and unused words are plain storage for the host
  always @(posedge clk_sys) begin
    if (wr_acc && sel_ins) begin
      ins_mem[ins_off[3:0]] <= pwdata; // [R13]
    end
  end

  // the header copy follows the header word so inserting logic reads a flop
  always @(posedge clk_sys) begin
    if (rst) begin
      insert_header <= 32'h00000000;
    end else if (wr_acc && host_word_addr == `STQT_INSERT_CELL_HEADER) begin
      insert_header <= pwdata; // [R14] [R15]
    end
  end

  // extraction cells are filled and read by the host only in this block
  always @(posedge clk_sys) begin
    if (wr_acc && sel_ext) begin
      ext_mem[ext_off[11:0]] <= pwdata; // [R16]
    end
  end

  // ---------------- read data, sampled in the setup cycle ----------------
  reg [31:0] next_rdata;
  reg [15:0] head;

  always @* begin
    next_rdata = 32'h00000000;
    head = q_mem[q_rd_ptr[QW-1:0]];
    if (sel_cnt) begin
      next_rdata = cnt_mem[cnt_off[11:0]];
    end else if (sel_thr) begin
      next_rdata = thr_mem[thr_off[11:0]];
    end else if (sel_q) begin
      if (!q_empty) begin
        // more entries remain after this head entry
        next_rdata = {16'h0000, q_level > {{QW{1'b0}}, 1'b1},
                      head[14:0]}; // [R4]
      end
    end else if (sel_tmr) begin
      next_rdata = {16'h0000, tmr_mem[tmr_off[3:0]]}; // [R7]
    end else if (sel_ins) begin
      next_rdata = ins_mem[ins_off[3:0]]; // [R13]
    end else if (sel_ext) begin
      next_rdata = ext_mem[ext_off[11:0]];
    end else if (sel_ctrl) begin
      next_rdata = ctrl;
    end else if (sel_stat) begin
      next_rdata = {16'h0000, irq_status_two, irq_status_one};
    end else if (sel_lvl) begin
      next_rdata = {19'h00000, q_level};
    end
  end

  // unmapped reads return zero together with the error flag
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= (!pwrite && mapped) ? next_rdata : 32'h00000000;
      pslverr <= !mapped;
    end
  end

endmodule // stqt_top

// file: test/stat_threshold_queue_timers_test.sv
// self-checking bench: buffers, threshold queue and timers over apb
`timescale 1ns/1ps
module stat_threshold_queue_timers_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic cnt_inc_valid = 1'b0;
  logic [11:0] cnt_inc_index = 12'h0;
  wire [31:0] prdata;
  wire [31:0] insert_header;
  wire pready, pslverr, cnt_inc_ready, pin1, pin2;
  integer seed = 84952;
  integer k;
  integer fails = 0;
  integer total_checks = 0;
  logic [31:0] rd, hdr;
  logic er;
  logic [11:0] ix;
  always #25 clk_sys = ~clk_sys;
  // short tick so timer expiry fits in a brief run
  stqt_top #(.TICK_CYCLES(8)) dut (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnt_inc_valid(cnt_inc_valid), .cnt_inc_index(cnt_inc_index),
    .cnt_inc_ready(cnt_inc_ready), .insert_header(insert_header),
    .timer_set1_irq_pin(pin1), .timer_set2_irq_pin(pin2));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: %h expected %h", $time, got, exp);
        fails = fails + 1;
      end
    end
  endtask
  // request held until the edge that samples pready high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    integer n;
    logic ok;
    begin
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n = n + 1) begin
        @(posedge clk_sys);
        ok = (pready === 1'b1);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (!ok) begin
        fails = fails + 1;
        stop_test;
      end
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [31:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task inc(input logic [11:0] i);
    integer n;
    logic ok;
    begin
      @(posedge clk_sys);
      cnt_inc_valid <= 1'b1; cnt_inc_index <= i;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n = n + 1) begin
        @(posedge clk_sys);
        ok = (cnt_inc_ready === 1'b1);
      end
      cnt_inc_valid <= 1'b0;
      if (!ok) begin
        fails = fails + 1;
        stop_test;
      end
    end
  endtask
  function logic [31:0] ca(input logic [11:0] i);
    ca = 32'h00020000 + {19'h0, i, 1'b0};
  endfunction
  function logic [31:0] ta(input logic [11:0] i);
    ta = 32'h00022000 + {19'h0, i, 1'b0};
  endfunction
  // queue entry as software sees it: more flag, port, channel, counter
  function logic [31:0] qe(input logic [11:0] i, input logic more);
    qe = {16'h0, more, 3'h0, i};
  endfunction
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    hdr = $random(seed);
    rc(32'h00100, 32'h3);
    wr(32'h26020, hdr);
    rc(32'h26020, hdr);
    chk(insert_header, hdr);
    wr(32'h26024, ~hdr);
    rc(32'h26024, ~hdr);
    wr(32'h27FFE, hdr);
    rc(32'h27FFE, hdr);
    rc(32'h00040000, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test buffers done");
    rd = $random(seed);
    ix = rd[11:0];
    wr(ca(ix), 32'h4);
    wr(ta(ix), 32'h80000005);
    wr(ca(ix ^ 12'h1), 32'h10);
    wr(ta(ix ^ 12'h1), 32'h80000011);
    wr(ca(ix ^ 12'h2), 32'h0);
    wr(ta(ix ^ 12'h2), 32'h00000001);
    wr(ca(ix ^ 12'h4), 32'h3FFFFFFF);
    wr(ta(ix ^ 12'h4), 32'hC0000001);
    inc(ix);
    inc(ix ^ 12'h1);
    inc(ix ^ 12'h2);
    inc(ix ^ 12'h4);
    inc(ix ^ 12'h4);
    inc(ix);
    rc(32'h00108, 32'h2);
    rc(32'h24000, qe(ix, 1'b1));
    rc(32'h24002, qe(ix ^ 12'h1, 1'b0));
    rc(32'h24000, 32'h0);
    rc(32'h00108, 32'h0);
    rc(ca(ix), 32'h80000006);
    rc(ca(ix ^ 12'h4), 32'h40000000);
    rc(ca(ix ^ 12'h2), 32'h1);
    $display("test queue done");
    for (k = 0; k < 16; k = k + 1) begin
      wr(32'h26000 + 2 * k, 32'h0);
    end
    wr(32'h00100, 32'h1);
    wr(32'h26000, 32'h8001);
    wr(32'h26010, 32'h8002);
    wr(32'h26012, 32'h0003);
    repeat (60) @(posedge clk_sys);
    rc(32'h26010, 32'h7FFF);
    rc(32'h26012, 32'h3);
    rc(32'h26000, 32'h8001);
    rc(32'h00104, 32'h1);
    chk({30'h0, pin1, pin2}, 32'h2);
    wr(32'h00100, 32'h3);
    repeat (60) @(posedge clk_sys);
    rc(32'h26000, 32'h7FFF);
    rc(32'h00104, 32'h101);
    chk({30'h0, pin1, pin2}, 32'h3);
    wr(32'h00104, 32'h101);
    rc(32'h00104, 32'h0);
    chk({30'h0, pin1, pin2}, 32'h0);
    $display("test timers done");
    stop_test;
  end
endmodule // stat_threshold_queue_timers_test

// file: test/stqt_top_properties.sv
// apb, increment port and header output checks for the block top
`timescale 1ns/1ps
module stqt_top_properties (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cnt_inc_valid,
  input wire [11:0] cnt_inc_index,
  input wire cnt_inc_ready,
  input wire [31:0] insert_header,
  input wire timer_set1_irq_pin,
  input wire timer_set2_irq_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire setup = psel && !penable;
  wire hdr_a = paddr == 32'h00026020;
  wire cnt_a = paddr >= 32'h00020000 && paddr <= 32'h00021FFF;
  wire que_a = paddr >= 32'h00024000 && paddr <= 32'h00025FFF;
  a_pready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_stall_write: assert property (acc && pwrite && !paddr[0] &&
    (cnt_a || que_a) |-> !cnt_inc_ready)
    else $error("increment taken during write");
  a_idle_ready: assert property (!psel |-> cnt_inc_ready)
    else $error("increment port stalled while bus idle");
  a_hdr_update: assert property (acc && pwrite && hdr_a |=>
    insert_header == $past(pwdata)) else $error("header not loaded");
  a_hdr_stable: assert property (!(acc && pwrite && hdr_a) |=>
    $stable(insert_header)) else $error("header changed");
  a_hdr_read: assert property (acc && !pwrite && hdr_a |->
    prdata == insert_header) else $error("header readback differs");
  a_err_range: assert property (setup && paddr[31:18] != 14'h0 |=>
    pslverr && prdata == 32'h0) else $error("unmapped access accepted");
  a_err_odd: assert property (setup && paddr[0] |=> pslverr)
    else $error("odd address accepted");
  c_queue_read: cover property (acc && !pwrite && que_a);
  c_irq_one: cover property ($rose(timer_set1_irq_pin));
  c_irq_two: cover property ($rose(timer_set2_irq_pin));
  c_error: cover property (acc && pslverr);
endmodule // stqt_top_properties
bind stqt_top stqt_top_properties chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cnt_inc_valid(cnt_inc_valid), .cnt_inc_index(cnt_inc_index),
  .cnt_inc_ready(cnt_inc_ready), .insert_header(insert_header),
  .timer_set1_irq_pin(timer_set1_irq_pin),
  .timer_set2_irq_pin(timer_set2_irq_pin));
